// ==== hdl/atar_alert_cmp.sv ====
`timescale 1ns/10ps
module atar_alert_cmp
    import atar_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // New result for this channel
    input wire logic update,
    input wire logic [13:0] result,
    input wire logic refSel,
    // Thresholds
    input wire logic [13:0] ratioLowSet,
    input wire logic [13:0] ratioLowClr,
    input wire logic [13:0] absHighSet,
    input wire logic [13:0] absHighClr,
    // Alert levels
    output logic lowAlert,
    output logic highAlert
);
    // Compare results, strict for set, inclusive for clear
    wire logic belowSet = result < ratioLowSet;
    wire logic atOrAboveClr = result >= ratioLowClr;
    wire logic aboveSet = result > absHighSet;
    wire logic atOrBelowClr = result <= absHighClr;
    wire logic isRatio = refSel == ATAR_REF_RATIO;

    // Set takes priority, so a misordered pair still alerts
    wire logic lowNxt = !isRatio ? 1'b0 : belowSet ? 1'b1 : atOrAboveClr ? 1'b0 : lowAlert;
    wire logic highNxt = isRatio ? 1'b0 : aboveSet ? 1'b1 : atOrBelowClr ? 1'b0 : highAlert;

    // Alert flops only move on a fresh result
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lowAlert <= 1'b0;
            highAlert <= 1'b0;
        end else if (update) begin
            lowAlert <= lowNxt;
            highAlert <= highNxt;
        end
    end

    // Result steps on each reference kind
    sequence sRatioUpd;
        update && refSel == ATAR_REF_RATIO;
    endsequence
    sequence sAbsUpd;
        update && refSel == ATAR_REF_ABS;
    endsequence

    a_low_alert_set: assert property (@(posedge mclk) disable iff (!resetn)
        sRatioUpd ##0 (result < ratioLowSet) |=> lowAlert)
        else $error("low alert not set below set threshold");
    a_low_alert_clear: assert property (@(posedge mclk) disable iff (!resetn)
        sRatioUpd ##0 (result >= ratioLowClr && result >= ratioLowSet) |=> !lowAlert)
        else $error("low alert not cleared at clear threshold");
    a_high_alert_set: assert property (@(posedge mclk) disable iff (!resetn)
        sAbsUpd ##0 (result > absHighSet) |=> highAlert)
        else $error("high alert not set above set threshold");
    a_high_alert_clear: assert property (@(posedge mclk) disable iff (!resetn)
        sAbsUpd ##0 (result <= absHighClr && result <= absHighSet) |=> !highAlert)
        else $error("high alert not cleared at clear threshold");
    a_hyst_hold_band: assert property (@(posedge mclk) disable iff (!resetn)
        sRatioUpd ##0 (result >= ratioLowSet && result < ratioLowClr) |=> $stable(lowAlert))
        else $error("low alert moved inside hysteresis band");
    a_low_check_off: assert property (@(posedge mclk) disable iff (!resetn)
        !lowAlert ##0 sRatioUpd ##0 (ratioLowSet == ATAR_TH_MIN) |=> !lowAlert)
        else $error("low alert set with zero set threshold");
    a_high_check_off: assert property (@(posedge mclk) disable iff (!resetn)
        (absHighSet == ATAR_TH_MAX && !highAlert) ##0 sAbsUpd |=> !highAlert)
        else $error("high alert set with full-scale set threshold");
endmodule : atar_alert_cmp

// ==== hdl/atar_regs.sv ====
`timescale 1ns/10ps
module atar_regs
    import atar_pkg::*;
#(
    parameter int unsigned NUM_AUX = ATAR_NUM_AUX
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Auxiliary conversion results
    input wire logic [13:0] auxResult,
    input wire logic [2:0] auxChan,
    input wire logic auxValid,
    // Alert levels and interrupt
    output logic [NUM_AUX-1:0] auxLowAlert,
    output logic [NUM_AUX-1:0] auxHighAlert,
    output logic irq
);
    // One event bit per channel per alert kind
    localparam int unsigned EVT_W = 2 * NUM_AUX;

    // Threshold storage, field only
    logic [13:0] ratioLowClr_r; // Ratiometric low alert clear level
    logic [13:0] ratioLowSet_r; // Ratiometric low alert set level
    logic [13:0] absHighClr_r; // Absolute high alert clear level
    logic [13:0] absHighSet_r; // Absolute high alert set level
    // Control and interrupt state
    logic [NUM_AUX-1:0] refSel_r; // One reference bit per input
    logic [EVT_W-1:0] intEn_r; // Interrupt enables
    logic [EVT_W-1:0] intStat_r; // Sticky alert-rise events
    logic [EVT_W-1:0] intStat_nxt; // Next sticky state
    logic [EVT_W-1:0] intEn_nxt; // Next enables
    logic irq_r; // Registered interrupt level
    logic [15:0] regRdData_r; // Registered read data
    // Previous alert levels for rise detection
    logic [NUM_AUX-1:0] lowPrev_r;
    logic [NUM_AUX-1:0] highPrev_r;
    wire logic [NUM_AUX-1:0] lowLvl; // From channel comparators
    wire logic [NUM_AUX-1:0] highLvl;

    // Address decode
    wire logic selRatioLowClr = regAddr == ATAR_ADDR_RATIO_LOW_CLR;
    wire logic selRatioLowSet = regAddr == ATAR_ADDR_RATIO_LOW_SET;
    wire logic selAbsHighClr = regAddr == ATAR_ADDR_ABS_HIGH_CLR;
    wire logic selAbsHighSet = regAddr == ATAR_ADDR_ABS_HIGH_SET;
    wire logic selRefSel = regAddr == ATAR_ADDR_REF_SEL;
    wire logic selAlertLvl = regAddr == ATAR_ADDR_ALERT_LVL;
    wire logic selIntStat = regAddr == ATAR_ADDR_INT_STAT;
    wire logic selIntClr = regAddr == ATAR_ADDR_INT_CLR;
    wire logic selIntEn = regAddr == ATAR_ADDR_INT_EN;

    // Write strobes per register
    wire logic wrRatioLowClr = regWr && selRatioLowClr;
    wire logic wrRatioLowSet = regWr && selRatioLowSet;
    wire logic wrAbsHighClr = regWr && selAbsHighClr;
    wire logic wrAbsHighSet = regWr && selAbsHighSet;
    wire logic wrRefSel = regWr && selRefSel;
    wire logic wrIntClr = regWr && selIntClr;
    wire logic wrIntEn = regWr && selIntEn;

    // Threshold field of the write data; low two bits dropped
    wire logic [13:0] wrField = regWrData[ATAR_TH_MSB:ATAR_TH_LSB];

    // Ratiometric low clear level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ratioLowClr_r <= ATAR_RST_RATIO_LOW_CLR;
        end else if (wrRatioLowClr) begin
            ratioLowClr_r <= wrField;
        end
    end

    // Ratiometric low set level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ratioLowSet_r <= ATAR_RST_RATIO_LOW_SET;
        end else if (wrRatioLowSet) begin
            ratioLowSet_r <= wrField;
        end
    end

    // Absolute high clear level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            absHighClr_r <= ATAR_RST_ABS_HIGH_CLR;
        end else if (wrAbsHighClr) begin
            absHighClr_r <= wrField;
        end
    end

    // Absolute high set level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            absHighSet_r <= ATAR_RST_ABS_HIGH_SET;
        end else if (wrAbsHighSet) begin
            absHighSet_r <= wrField;
        end
    end

    // Reference select; changing it leaves alerts until the next result
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            refSel_r <= ATAR_RST_REF_SEL[NUM_AUX-1:0];
        end else if (wrRefSel) begin
            refSel_r <= regWrData[NUM_AUX-1:0];
        end
    end

    // One comparator per auxiliary input
    genvar ch;
    generate
        for (ch = 0; ch < NUM_AUX; ch = ch + 1) begin : gChan
            // Result belongs to this input
            wire logic chUpd = auxValid && (auxChan == ATAR_CHAN_W'(ch));
            atar_alert_cmp uCmp (
                .mclk(mclk),
                .resetn(resetn),
                .update(chUpd),
                .result(auxResult),
                .refSel(refSel_r[ch]),
                .ratioLowSet(ratioLowSet_r),
                .ratioLowClr(ratioLowClr_r),
                .absHighSet(absHighSet_r),
                .absHighClr(absHighClr_r),
                .lowAlert(lowLvl[ch]),
                .highAlert(highLvl[ch])
            );
        end
    endgenerate

    // Rising edges of alert levels are the interrupt events
    wire logic [EVT_W-1:0] evtRise = {highLvl & ~highPrev_r, lowLvl & ~lowPrev_r};
    // Clear mask only on a write to the clear register
    wire logic [EVT_W-1:0] clrMask = wrIntClr ? regWrData[EVT_W-1:0] : {EVT_W{1'b0}};

    // Sticky status: an event in the clearing cycle survives
    always_comb begin
        intStat_nxt = (intStat_r & ~clrMask) | evtRise;
        intEn_nxt = wrIntEn ? regWrData[EVT_W-1:0] : intEn_r;
    end

    // Previous levels for edge detection
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lowPrev_r <= '0;
            highPrev_r <= '0;
        end else begin
            lowPrev_r <= lowLvl;
            highPrev_r <= highLvl;
        end
    end

    // Status, enable and interrupt level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            intStat_r <= ATAR_RST_INT_STAT[EVT_W-1:0];
            intEn_r <= ATAR_RST_INT_EN[EVT_W-1:0];
            irq_r <= 1'b0;
        end else begin
            intStat_r <= intStat_nxt;
            intEn_r <= intEn_nxt;
            // Computed from next state so irq tracks status exactly
            irq_r <= |(intStat_nxt & intEn_nxt);
        end
    end

    // Read selection; unmapped and write-only offsets read zero
    wire logic [15:0] rdThresh = selRatioLowClr ? {ratioLowClr_r, ATAR_TH_PAD} :
                                 selRatioLowSet ? {ratioLowSet_r, ATAR_TH_PAD} :
                                 selAbsHighClr ? {absHighClr_r, ATAR_TH_PAD} :
                                 selAbsHighSet ? {absHighSet_r, ATAR_TH_PAD} : 16'h0000;
    wire logic [15:0] rdCtrl = selRefSel ? 16'(refSel_r) :
                               selAlertLvl ? 16'({highLvl, lowLvl}) :
                               selIntStat ? 16'(intStat_r) :
                               selIntEn ? 16'(intEn_r) : 16'h0000;
    wire logic [15:0] rdMux = rdThresh | rdCtrl;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdData_r <= 16'h0000;
        end else begin
            regRdData_r <= regRd ? rdMux : 16'h0000;
        end
    end

    // Outputs straight from flops
    assign regRdData = regRdData_r;
    assign auxLowAlert = lowLvl;
    assign auxHighAlert = highLvl;
    assign irq = irq_r;

    // Write then read of a threshold
    sequence sWrThenRdSet;
        regWr && selRatioLowSet ##1 regRd && selRatioLowSet && !regWr;
    endsequence

    a_thresh_read_back: assert property (@(posedge mclk) disable iff (!resetn)
        sWrThenRdSet |=> regRdData == {$past(regWrData[15:2], 2), ATAR_TH_PAD})
        else $error("threshold read back differs from write");
    a_thresh_low_pad: assert property (@(posedge mclk) disable iff (!resetn)
        regRd && (selRatioLowClr || selRatioLowSet || selAbsHighClr || selAbsHighSet)
        |=> regRdData[1:0] == ATAR_TH_PAD)
        else $error("unused threshold bits read nonzero");
    a_abs_set_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !(regWr && selAbsHighSet) |=> $stable(absHighSet_r))
        else $error("absolute set level changed without a write");
    a_event_beats_clear: assert property (@(posedge mclk) disable iff (!resetn)
        (evtRise[0] && wrIntClr && regWrData[0]) |=> intStat_r[0])
        else $error("event lost under simultaneous clear");
    a_irq_tracks_stat: assert property (@(posedge mclk) disable iff (!resetn)
        irq == |(intStat_r & intEn_r))
        else $error("interrupt level disagrees with enabled status");
    a_rd_idle_zero: assert property (@(posedge mclk) disable iff (!resetn)
        !regRd |=> regRdData == 16'h0000)
        else $error("read data present without a read strobe");
    a_low_rise_event: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(lowLvl[0]) |=> intStat_r[0] && lowPrev_r[0])
        else $error("low alert rise did not set status");

    // Each threshold write lands as its 14-bit field on the next edge
    a_wr_ratio_clr: assert property (@(posedge mclk) disable iff (!resetn)
        wrRatioLowClr |=> ratioLowClr_r == $past(regWrData[15:2]))
        else $error("ratiometric clear level not written");
    a_wr_ratio_set: assert property (@(posedge mclk) disable iff (!resetn)
        wrRatioLowSet |=> ratioLowSet_r == $past(regWrData[15:2]))
        else $error("ratiometric set level not written");
    a_wr_abs_clr: assert property (@(posedge mclk) disable iff (!resetn)
        wrAbsHighClr |=> absHighClr_r == $past(regWrData[15:2]))
        else $error("absolute clear level not written");
    a_wr_abs_set: assert property (@(posedge mclk) disable iff (!resetn)
        wrAbsHighSet |=> absHighSet_r == $past(regWrData[15:2]))
        else $error("absolute set level not written");

    // Levels move only on their own write, so a stray strobe cannot leak in
    a_ratio_clr_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !wrRatioLowClr |=> $stable(ratioLowClr_r))
        else $error("ratiometric clear level changed without a write");
    a_ratio_set_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !wrRatioLowSet |=> $stable(ratioLowSet_r))
        else $error("ratiometric set level changed without a write");
    a_abs_clr_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !wrAbsHighClr |=> $stable(absHighClr_r))
        else $error("absolute clear level changed without a write");
    a_refsel_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !wrRefSel |=> $stable(refSel_r))
        else $error("reference select changed without a write");

    // Enables follow their register writes only
    a_en_write: assert property (@(posedge mclk) disable iff (!resetn)
        wrIntEn |=> intEn_r == $past(regWrData[EVT_W-1:0]))
        else $error("interrupt enables not written");
    a_en_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !wrIntEn |=> $stable(intEn_r))
        else $error("interrupt enables changed without a write");

    // Clearing drops a status bit unless its event arrives in the same cycle
    sequence sClrLow0;
        wrIntClr && regWrData[0];
    endsequence
    a_stat_clear: assert property (@(posedge mclk) disable iff (!resetn)
        sClrLow0 ##0 !evtRise[0] |=> !intStat_r[0])
        else $error("status bit survived its clear");
    a_stat_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        intStat_r[0] && !(wrIntClr && regWrData[0]) |=> intStat_r[0])
        else $error("status bit dropped without a clear");

    // High alert rise of input 1 lands in the upper half of status
    a_high_rise_event: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(highLvl[1]) |=> intStat_r[NUM_AUX+1] && highPrev_r[1])
        else $error("high alert rise did not set status");

    // Level and select reads show the values seen at the strobe
    a_rd_alert_lvl: assert property (@(posedge mclk) disable iff (!resetn)
        regRd && selAlertLvl |=> regRdData[EVT_W-1:0] == $past({highLvl, lowLvl}))
        else $error("alert level read differs from alerts");
    a_rd_ref_sel: assert property (@(posedge mclk) disable iff (!resetn)
        regRd && selRefSel |=> regRdData[NUM_AUX-1:0] == $past(refSel_r))
        else $error("reference select read differs from register");

    // Unmapped and write-only offsets read as zero
    a_rd_unmapped: assert property (@(posedge mclk) disable iff (!resetn)
        regRd && !(selRatioLowClr || selRatioLowSet || selAbsHighClr || selAbsHighSet ||
                   selRefSel || selAlertLvl || selIntStat || selIntEn)
        |=> regRdData == 16'h0000)
        else $error("unmapped read returned data");

    // The alert of the other reference kind is forced off on each result
    a_abs_no_low: assert property (@(posedge mclk) disable iff (!resetn)
        auxValid && auxChan == 3'h1 && refSel_r[1] == ATAR_REF_ABS |=> !lowLvl[1])
        else $error("absolute input shows a low alert");
    a_ratio_no_high: assert property (@(posedge mclk) disable iff (!resetn)
        auxValid && auxChan == 3'h0 && refSel_r[0] == ATAR_REF_RATIO |=> !highLvl[0])
        else $error("ratiometric input shows a high alert");
endmodule : atar_regs

// ==== inc/atar_pkg.sv ====
package atar_pkg;
    // Register port geometry
    localparam int unsigned ATAR_ADDR_W = 8;
    localparam int unsigned ATAR_REG_W = 16;
    // Threshold field sits in bits 15:2, bits 1:0 read as zero
    localparam int unsigned ATAR_TH_W = 14;
    localparam int unsigned ATAR_TH_LSB = 2;
    localparam int unsigned ATAR_TH_MSB = 15;
    localparam logic [1:0] ATAR_TH_PAD = 2'h0;
    // Threshold register offsets
    localparam logic [7:0] ATAR_ADDR_RATIO_LOW_CLR = 8'h32;
    localparam logic [7:0] ATAR_ADDR_RATIO_LOW_SET = 8'h33;
    localparam logic [7:0] ATAR_ADDR_ABS_HIGH_CLR = 8'h34;
    localparam logic [7:0] ATAR_ADDR_ABS_HIGH_SET = 8'h35;
    // Control, level and interrupt registers
    localparam logic [7:0] ATAR_ADDR_REF_SEL = 8'h40;
    localparam logic [7:0] ATAR_ADDR_ALERT_LVL = 8'h41;
    localparam logic [7:0] ATAR_ADDR_INT_STAT = 8'h42;
    localparam logic [7:0] ATAR_ADDR_INT_CLR = 8'h43;
    localparam logic [7:0] ATAR_ADDR_INT_EN = 8'h44;
    // Threshold reset values (14-bit field values)
    localparam logic [13:0] ATAR_RST_RATIO_LOW_CLR = 14'h0000;
    localparam logic [13:0] ATAR_RST_RATIO_LOW_SET = 14'h0000;
    localparam logic [13:0] ATAR_RST_ABS_HIGH_CLR = 14'h3fff;
    localparam logic [13:0] ATAR_RST_ABS_HIGH_SET = 14'h3fff;
    // Extremes that switch a check off
    localparam logic [13:0] ATAR_TH_MIN = 14'h0000;
    localparam logic [13:0] ATAR_TH_MAX = 14'h3fff;
    // Control and interrupt reset values
    localparam logic [15:0] ATAR_RST_REF_SEL = 16'h0000;
    localparam logic [15:0] ATAR_RST_INT_EN = 16'h0000;
    localparam logic [15:0] ATAR_RST_INT_STAT = 16'h0000;
    // Reference select encodings
    localparam logic ATAR_REF_RATIO = 1'b0;
    localparam logic ATAR_REF_ABS = 1'b1;
    // Default channel count and index width
    localparam int unsigned ATAR_NUM_AUX = 6;
    localparam int unsigned ATAR_CHAN_W = 3;
endpackage : atar_pkg

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import atar_pkg::*;
    // Six inputs, the design default
    localparam int unsigned NAUX = 6;
    // Clock, reset and register port stimulus
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    // Conversion result stimulus
    logic [13:0] auxResult = 14'h0000;
    logic [2:0] auxChan = 3'h0;
    logic auxValid = 1'b0;
    // Observed outputs
    logic [15:0] regRdData;
    logic [NAUX-1:0] auxLowAlert;
    logic [NAUX-1:0] auxHighAlert;
    logic irq;
    // Alert levels the bench expects, updated per result
    logic [NAUX-1:0] expLow = '0;
    logic [NAUX-1:0] expHigh = '0;
    // Score counters
    int err_total = 0;
    int checked = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    atar_regs #(.NUM_AUX(NAUX)) u_dut (
        .mclk(mclk),
        .resetn(resetn),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData),
        .auxResult(auxResult),
        .auxChan(auxChan),
        .auxValid(auxValid),
        .auxLowAlert(auxLowAlert),
        .auxHighAlert(auxHighAlert),
        .irq(irq)
    );

    // Compare and count, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data only stands in the following cycle
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask : rd

    // Deliver one result, then check every alert level one cycle on
    task automatic res(input logic [2:0] ch, input logic [13:0] r, input logic el, input logic eh);
        @(posedge mclk);
        auxValid <= 1'b1;
        auxChan <= ch;
        auxResult <= r;
        @(posedge mclk);
        auxValid <= 1'b0;
        #1;
        // Out-of-range channels must leave every alert alone
        if (ch < NAUX) begin
            expLow[ch] = el;
            expHigh[ch] = eh;
        end
        chk({10'h000, auxLowAlert}, {10'h000, expLow});
        chk({10'h000, auxHighAlert}, {10'h000, expHigh});
    endtask : res

    // Interrupt line, sampled settled
    task automatic chkIrq(input logic exp);
        #1;
        chk({15'h0000, irq}, {15'h0000, exp});
    endtask : chkIrq

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask : done

    // Single exit point of the run
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the hundred-odd cycles the tests need
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values and field placement
        rd(ATAR_ADDR_RATIO_LOW_CLR, 16'h0000);
        rd(ATAR_ADDR_RATIO_LOW_SET, 16'h0000);
        rd(ATAR_ADDR_ABS_HIGH_CLR, 16'hfffc);
        rd(ATAR_ADDR_ABS_HIGH_SET, 16'hfffc);
        rd(ATAR_ADDR_INT_STAT, 16'h0000);
        done("reset_values");
        // Disabled checks at reset thresholds: zero low set, full-scale high set
        res(3'h0, 14'h0000, 1'b0, 1'b0);
        wr(ATAR_ADDR_REF_SEL, 16'h0002);
        rd(ATAR_ADDR_REF_SEL, 16'h0002);
        res(3'h1, 14'h3fff, 1'b0, 1'b0);
        done("disabled_checks");
        // Unused low bits dropped, last value read back
        wr(ATAR_ADDR_RATIO_LOW_SET, 16'habcf);
        rd(ATAR_ADDR_RATIO_LOW_SET, 16'habcc);
        // Back-to-back write then read, no idle cycle between strobes
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= ATAR_ADDR_RATIO_LOW_SET;
        regWrData <= 16'h1235;
        @(posedge mclk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, 16'h1234);
        wr(ATAR_ADDR_RATIO_LOW_SET, 16'h0403);
        wr(ATAR_ADDR_RATIO_LOW_CLR, 16'h0800);
        wr(ATAR_ADDR_ABS_HIGH_SET, 16'hc000);
        wr(ATAR_ADDR_ABS_HIGH_CLR, 16'h8000);
        rd(ATAR_ADDR_RATIO_LOW_SET, 16'h0400);
        rd(ATAR_ADDR_RATIO_LOW_CLR, 16'h0800);
        rd(ATAR_ADDR_ABS_HIGH_SET, 16'hc000);
        rd(ATAR_ADDR_ABS_HIGH_CLR, 16'h8000);
        // Unmapped and read-only places
        wr(8'h50, 16'hffff);
        rd(8'h50, 16'h0000);
        wr(ATAR_ADDR_INT_STAT, 16'hffff);
        rd(ATAR_ADDR_INT_STAT, 16'h0000);
        done("register_access");
        // Ratiometric input 0: set 0x100, clear 0x200
        res(3'h0, 14'h0100, 1'b0, 1'b0);
        res(3'h0, 14'h00ff, 1'b1, 1'b0);
        res(3'h0, 14'h0180, 1'b1, 1'b0);
        res(3'h0, 14'h01ff, 1'b1, 1'b0);
        res(3'h7, 14'h3fff, 1'b0, 1'b0);
        // Absolute input 1: set 0x3000, clear 0x2000
        res(3'h1, 14'h3000, 1'b0, 1'b0);
        res(3'h1, 14'h3001, 1'b0, 1'b1);
        res(3'h1, 14'h2800, 1'b0, 1'b1);
        res(3'h1, 14'h2001, 1'b0, 1'b1);
        rd(ATAR_ADDR_ALERT_LVL, 16'h0081);
        res(3'h0, 14'h0200, 1'b0, 1'b0);
        res(3'h0, 14'h0180, 1'b0, 1'b0);
        res(3'h1, 14'h2000, 1'b0, 1'b0);
        res(3'h1, 14'h2800, 1'b0, 1'b0);
        done("alert_hysteresis");
        // Sticky status: low rise of input 0 is bit 0, high rise of input 1 is bit 7
        rd(ATAR_ADDR_INT_STAT, 16'h0081);
        chkIrq(1'b0);
        wr(ATAR_ADDR_INT_EN, 16'h0001);
        chkIrq(1'b1);
        wr(ATAR_ADDR_INT_CLR, 16'h0081);
        chkIrq(1'b0);
        rd(ATAR_ADDR_INT_STAT, 16'h0000);
        rd(ATAR_ADDR_INT_CLR, 16'h0000);
        // Masked event stays pending, then fires once enabled
        wr(ATAR_ADDR_INT_EN, 16'h0080);
        res(3'h0, 14'h0000, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        chkIrq(1'b0);
        rd(ATAR_ADDR_INT_STAT, 16'h0001);
        rd(ATAR_ADDR_INT_EN, 16'h0080);
        wr(ATAR_ADDR_INT_EN, 16'h0081);
        chkIrq(1'b1);
        wr(ATAR_ADDR_INT_CLR, 16'h0001);
        chkIrq(1'b0);
        // Event and clear in one cycle: the event must win
        res(3'h0, 14'h0200, 1'b0, 1'b0);
        @(posedge mclk);
        auxValid <= 1'b1;
        auxResult <= 14'h0000;
        @(posedge mclk);
        auxValid <= 1'b0;
        regWr <= 1'b1;
        regAddr <= ATAR_ADDR_INT_CLR;
        regWrData <= 16'h0001;
        @(posedge mclk);
        regWr <= 1'b0;
        rd(ATAR_ADDR_INT_STAT, 16'h0001);
        expLow[0] = 1'b1;
        chk({10'h000, auxLowAlert}, {10'h000, expLow});
        chkIrq(1'b1);
        wr(ATAR_ADDR_INT_CLR, 16'h0001);
        chkIrq(1'b0);
        done("interrupts");
        // Second reset in mid-run restores levels and thresholds
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        chkIrq(1'b0);
        chk({10'h000, auxLowAlert}, 16'h0000);
        chk({10'h000, auxHighAlert}, 16'h0000);
        @(posedge mclk);
        resetn <= 1'b1;
        expLow = '0;
        expHigh = '0;
        rd(ATAR_ADDR_RATIO_LOW_SET, 16'h0000);
        rd(ATAR_ADDR_ABS_HIGH_CLR, 16'hfffc);
        rd(ATAR_ADDR_REF_SEL, 16'h0000);
        res(3'h0, 14'h0000, 1'b0, 1'b0);
        done("second_reset");
        wrap_up();
    end
endmodule : tb_top
